/* File: src/async_serial_ports.sv */
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module async_serial_ports (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [async_serial_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [async_serial_pkg::NUM_PORTS-1:0] RXD,
  output logic [async_serial_pkg::NUM_PORTS-1:0] TXD,
  input wire logic FIXED_PORT_BAUD_PIN,
  input wire logic PORT_A_BAUD_PIN,
  input wire logic PORT_B_BAUD_PIN,
  input wire logic TOGGLE_TIMER_FOUR,
  input wire logic TIMER_ZERO_HIGH_PWM_OUTPUT,
  input wire logic LOW_SPEED_CRYSTAL_CLOCK,
  input wire logic CERAMIC_MAIN_CLOCK,
  output logic [async_serial_pkg::NUM_PORTS-1:0] RX_EVENT,
  output logic WAKE
);
  import async_serial_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers

  logic [1:0] rst_sync_reg;
  logic rst_n;

  // Not gated by CE so a frozen block still leaves reset
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  logic [SYN_W-1:0] ext_in;
  logic [SYN_W-1:0] sync1_reg;
  logic [SYN_W-1:0] sync2_reg;
  logic [SYN_W-1:0] sync3_reg;
  logic [SYN_W-1:0] rise;

  assign ext_in = {CERAMIC_MAIN_CLOCK, LOW_SPEED_CRYSTAL_CLOCK, TIMER_ZERO_HIGH_PWM_OUTPUT,
    TOGGLE_TIMER_FOUR, PORT_B_BAUD_PIN, PORT_A_BAUD_PIN, FIXED_PORT_BAUD_PIN, RXD};

  genvar s;
  generate
    for (s = 0; s < SYN_W; s++) begin : g_sync
      // Idle-high reset so no false start bit or edge at release
      always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          sync1_reg[s] <= 1'b1;
          sync2_reg[s] <= 1'b1;
          sync3_reg[s] <= 1'b1;
        end else if (CE) begin
          sync1_reg[s] <= ext_in[s];
          sync2_reg[s] <= sync1_reg[s];
          sync3_reg[s] <= sync2_reg[s];
        end
      end
      // One source period ends at each rising edge
      assign rise[s] = sync2_reg[s] & ~sync3_reg[s];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic [1:0] port_sel;
  logic [3:0] reg_ofs;
  logic mapped;
  logic wr_en;
  logic [31:0] rd_word [NUM_PORTS];
  logic [31:0] rd_mux;
  logic [31:0] prdata_reg;

  assign port_sel = PADDR[5:4];
  assign reg_ofs = PADDR[3:0];
  assign mapped = (PADDR[7:6] == 2'h0) && (port_sel <= PORT_FIELD_MAX) && (PADDR[1:0] == 2'h0);
  assign wr_en = PSEL && PENABLE && PWRITE && mapped && CE;
  // Frozen block stalls the bus; writes wait for CE, but a read set up while CE is low returns stale data
  assign PREADY = CE;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign rd_mux = mapped ? rd_word[port_sel] : 32'h0000_0000;
  assign PRDATA = prdata_reg;

  // Read data captured in the setup cycle, stable through access
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (CE && PSEL && !PENABLE && !PWRITE) begin
      prdata_reg <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port registers, baud source and serial lane

  logic [NUM_PORTS-1:0] rx_done_flag;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      localparam bit IS_FIXED = (p == 0);

      logic [CTRL_W-1:0] ctrl_reg;
      logic [DIV_W-1:0] div_reg;
      logic [DIV_W-1:0] div_next;
      logic [DATA_BITS-1:0] tx_data_reg;
      logic tx_go_reg;
      logic [DATA_BITS-1:0] rx_data_reg;
      logic rx_done_reg;
      logic perr_reg;
      logic ferr_reg;
      logic ovr_reg;
      logic tx_done_reg;
      logic hit;
      logic clr_stat;
      logic src_tick;

      serial_lane_if lane_bus();

      assign hit = wr_en && (port_sel == 2'(p));
      assign clr_stat = hit && (reg_ofs == OFS_STAT);

      always_comb begin
        if (PWDATA[DIV_W-1:0] < DIV_MIN) begin
          div_next = DIV_MIN;
        end else if (PWDATA[DIV_W-1:0] > DIV_MAX) begin
          div_next = DIV_MAX;
        end else begin
          div_next = PWDATA[DIV_W-1:0];
        end
      end

      always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          ctrl_reg <= CTRL_RST;
          div_reg <= DIV_RST;
        end else if (hit && (reg_ofs == OFS_CTRL)) begin
          ctrl_reg <= PWDATA[CTRL_W-1:0];
        end else if (hit && (reg_ofs == OFS_DIV)) begin
          div_reg <= div_next;
        end
      end

      // Write during a frame is dropped by the lane; a write while the start is pending replaces the byte
      always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          tx_data_reg <= 8'h00;
          tx_go_reg <= 1'b0;
        end else if (CE) begin
          tx_go_reg <= hit && (reg_ofs == OFS_TXDATA);
          if (hit && (reg_ofs == OFS_TXDATA)) begin
            tx_data_reg <= PWDATA[DATA_BITS-1:0];
          end
        end
      end

      // Baud source selection
      always_comb begin
        if (IS_FIXED) begin
          unique case (ctrl_reg[CTRL_SRC_LSB +: 2])
            2'h1: src_tick = rise[SYN_TMR4];
            2'h2: src_tick = rise[SYN_PWM];
            default: src_tick = rise[SYN_PIN0];
          endcase
        end else begin
          unique case (src_e'(ctrl_reg[CTRL_SRC_LSB +: 2]))
            SRC_SYS: src_tick = 1'b1;
            SRC_XTAL: src_tick = rise[SYN_XTAL];
            SRC_CER: src_tick = rise[SYN_CER];
            SRC_PIN: src_tick = rise[SYN_PIN0 + p];
          endcase
        end
      end

      assign lane_bus.enable = ctrl_reg[CTRL_EN_BIT];
      assign lane_bus.tick = src_tick;
      assign lane_bus.bit_len = IS_FIXED ? (ctrl_reg[CTRL_FIXED8_BIT] ? FIXED_LONG : FIXED_SHORT) : div_reg;
      assign lane_bus.parity = ctrl_reg[CTRL_PAR_LSB +: 2];
      assign lane_bus.two_stop = IS_FIXED ? 1'b0 : ctrl_reg[CTRL_TWO_STOP_BIT];
      assign lane_bus.tx_start = tx_go_reg;
      assign lane_bus.tx_data = tx_data_reg;
      assign lane_bus.rxd = sync2_reg[SYN_RXD + p];
      assign TXD[p] = lane_bus.txd;

      serial_lane u_lane (
        .clk(CLK),
        .rst_n(rst_n),
        .ce(CE),
        .lk(lane_bus)
      );

      always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          rx_data_reg <= 8'h00;
          rx_done_reg <= 1'b0;
          perr_reg <= 1'b0;
          ferr_reg <= 1'b0;
          ovr_reg <= 1'b0;
          tx_done_reg <= 1'b0;
        end else if (CE) begin
          if (lane_bus.rx_valid) begin
            rx_data_reg <= lane_bus.rx_data;
            rx_done_reg <= 1'b1;
            perr_reg <= lane_bus.rx_perr | (perr_reg & ~(clr_stat & PWDATA[STAT_PERR_BIT]));
            ferr_reg <= lane_bus.rx_ferr | (ferr_reg & ~(clr_stat & PWDATA[STAT_FERR_BIT]));
            // Unread character overwritten
            if (rx_done_reg && !(clr_stat && PWDATA[STAT_RX_DONE_BIT])) begin
              ovr_reg <= 1'b1;
            end else if (clr_stat && PWDATA[STAT_OVR_BIT]) begin
              ovr_reg <= 1'b0;
            end
          end else if (clr_stat) begin
            rx_done_reg <= rx_done_reg & ~PWDATA[STAT_RX_DONE_BIT];
            perr_reg <= perr_reg & ~PWDATA[STAT_PERR_BIT];
            ferr_reg <= ferr_reg & ~PWDATA[STAT_FERR_BIT];
            ovr_reg <= ovr_reg & ~PWDATA[STAT_OVR_BIT];
          end
          if (lane_bus.tx_done) begin
            tx_done_reg <= 1'b1;
          end else if (clr_stat && PWDATA[STAT_TX_DONE_BIT]) begin
            tx_done_reg <= 1'b0;
          end
        end
      end

      assign rx_done_flag[p] = rx_done_reg;

      always_comb begin
        rd_word[p] = 32'h0000_0000;
        unique case (reg_ofs)
          OFS_CTRL: rd_word[p][CTRL_W-1:0] = ctrl_reg;
          OFS_DIV: rd_word[p][DIV_W-1:0] = div_reg;
          OFS_TXDATA: rd_word[p][DATA_BITS-1:0] = tx_data_reg;
          OFS_STAT: begin
            rd_word[p][DATA_BITS-1:0] = rx_data_reg;
            rd_word[p][STAT_RX_DONE_BIT] = rx_done_reg;
            rd_word[p][STAT_PERR_BIT] = perr_reg;
            rd_word[p][STAT_FERR_BIT] = ferr_reg;
            rd_word[p][STAT_OVR_BIT] = ovr_reg;
            rd_word[p][STAT_TX_DONE_BIT] = tx_done_reg;
            rd_word[p][STAT_TX_BUSY_BIT] = lane_bus.tx_busy;
          end
          default: rd_word[p] = 32'h0000_0000;
        endcase
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Event outputs

  assign RX_EVENT = rx_done_flag;
  assign WAKE = rx_done_flag[1] | rx_done_flag[2];
endmodule

/* File: pkg/async_serial_pkg.sv */
package async_serial_pkg;
  localparam int NUM_PORTS = 3;
  localparam int DATA_BITS = 8;
  localparam int DIV_W = 13;
  localparam int CTRL_W = 7;
  localparam int ADDR_W = 8;

  // Bit period limits, in baud source periods
  localparam logic [DIV_W-1:0] DIV_MIN = 13'h0008;
  localparam logic [DIV_W-1:0] DIV_MAX = 13'h1000;
  localparam logic [DIV_W-1:0] FIXED_SHORT = 13'h0004;
  localparam logic [DIV_W-1:0] FIXED_LONG = 13'h0008;
  localparam logic [DIV_W-1:0] DIV_RST = 13'h0008;

  // Register map: one 16-byte window per port
  localparam logic [1:0] PORT_FIELD_MAX = 2'h2;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_DIV = 4'h4;
  localparam logic [3:0] OFS_TXDATA = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hc;

  // Control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PAR_LSB = 1;
  localparam int CTRL_TWO_STOP_BIT = 3;
  localparam int CTRL_SRC_LSB = 4;
  localparam int CTRL_FIXED8_BIT = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

  // Status field positions (data in [7:0])
  localparam int STAT_RX_DONE_BIT = 8;
  localparam int STAT_PERR_BIT = 9;
  localparam int STAT_FERR_BIT = 10;
  localparam int STAT_OVR_BIT = 11;
  localparam int STAT_TX_DONE_BIT = 12;
  localparam int STAT_TX_BUSY_BIT = 13;

  // Positions in the synchronised input vector
  localparam int SYN_RXD = 0;
  localparam int SYN_PIN0 = 3;
  localparam int SYN_TMR4 = 6;
  localparam int SYN_PWM = 7;
  localparam int SYN_XTAL = 8;
  localparam int SYN_CER = 9;
  localparam int SYN_W = 10;

  typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_EVEN = 2'b01, PAR_ODD = 2'b10} parity_e;
  typedef enum logic [1:0] {SRC_SYS = 2'b00, SRC_XTAL = 2'b01, SRC_CER = 2'b10, SRC_PIN = 2'b11} src_e;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10, RX_STOP = 2'b11} rx_state_e;
endpackage

/* File: pkg/serial_lane_if.sv */
`timescale 1ns/1ps
interface serial_lane_if;
  import async_serial_pkg::*;
  logic enable;
  logic tick;
  logic [DIV_W-1:0] bit_len;
  logic [1:0] parity;
  logic two_stop;
  logic tx_start;
  logic [DATA_BITS-1:0] tx_data;
  logic tx_busy;
  logic tx_done;
  logic rxd;
  logic txd;
  logic [DATA_BITS-1:0] rx_data;
  logic rx_valid;
  logic rx_perr;
  logic rx_ferr;
  modport ctrl(output enable, tick, bit_len, parity, two_stop, tx_start, tx_data, rxd,
    input tx_busy, tx_done, txd, rx_data, rx_valid, rx_perr, rx_ferr);
  modport lane(input enable, tick, bit_len, parity, two_stop, tx_start, tx_data, rxd,
    output tx_busy, tx_done, txd, rx_data, rx_valid, rx_perr, rx_ferr);
endinterface

/* File: src/serial_lane.sv */
`timescale 1ns/1ps
module serial_lane (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  serial_lane_if.lane lk
);
  import async_serial_pkg::*;

  logic [11:0] tx_shift_reg;
  logic [3:0] tx_left_reg;
  logic tx_pend_reg;
  logic [DIV_W-1:0] tx_cnt_reg;
  logic has_par;
  logic tx_par;
  logic tx_bit_end;
  logic [11:0] tx_frame;
  logic [3:0] tx_len;

  assign has_par = (lk.parity == PAR_EVEN) || (lk.parity == PAR_ODD);
  assign tx_par = (lk.parity == PAR_ODD) ? ~^lk.tx_data : ^lk.tx_data;
  assign tx_frame = has_par ? {2'b11, tx_par, lk.tx_data, 1'b0} : {3'b111, lk.tx_data, 1'b0};
  assign tx_len = 4'ha + {3'h0, has_par} + {3'h0, lk.two_stop};
  assign tx_bit_end = lk.tick && (tx_cnt_reg == lk.bit_len - 13'h0001);
  assign lk.tx_busy = (tx_left_reg != 4'h0) || tx_pend_reg;
  assign lk.tx_done = (tx_left_reg == 4'h1) && tx_bit_end;
  assign lk.txd = tx_shift_reg[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_reg <= 12'hfff;
      tx_left_reg <= 4'h0;
      tx_cnt_reg <= '0;
      tx_pend_reg <= 1'b0;
    end else if (ce) begin
      if (tx_left_reg == 4'h0) begin
        // launch on a tick so the start bit is whole
        if (tx_pend_reg && lk.tick) begin
          tx_shift_reg <= tx_frame;
          tx_left_reg <= tx_len;
          tx_cnt_reg <= '0;
          tx_pend_reg <= 1'b0;
        end else if (lk.tx_start && lk.enable) begin
          tx_pend_reg <= 1'b1;
        end
      end else if (tx_bit_end) begin
        tx_cnt_reg <= '0;
        tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
      end else if (lk.tick) begin
        tx_cnt_reg <= tx_cnt_reg + 13'h0001;
      end
    end
  end

  rx_state_e rx_state_reg;
  logic [DIV_W-1:0] rx_cnt_reg;
  logic [3:0] rx_idx_reg;
  logic [8:0] rx_shift_reg;
  logic rx_prev_reg;
  logic [DATA_BITS-1:0] rx_data_reg;
  logic rx_valid_reg;
  logic rx_perr_reg;
  logic rx_ferr_reg;
  logic rx_bit_end;
  logic rx_exp_par;

  assign rx_bit_end = lk.tick && (rx_cnt_reg == lk.bit_len - 13'h0001);
  assign rx_exp_par = (lk.parity == PAR_ODD) ? ~^rx_shift_reg[7:0] : ^rx_shift_reg[7:0];
  assign lk.rx_data = rx_data_reg;
  assign lk.rx_valid = rx_valid_reg;
  assign lk.rx_perr = rx_perr_reg;
  assign lk.rx_ferr = rx_ferr_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= '0;
      rx_idx_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_prev_reg <= 1'b1;
      rx_data_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
      rx_perr_reg <= 1'b0;
      rx_ferr_reg <= 1'b0;
    end else if (ce) begin
      rx_prev_reg <= lk.rxd;
      rx_valid_reg <= 1'b0;
      if (!lk.enable) begin
        rx_state_reg <= RX_IDLE;
      end else begin
        unique case (rx_state_reg)
          RX_IDLE: begin
            if (rx_prev_reg && !lk.rxd) begin
              rx_state_reg <= RX_START;
              rx_cnt_reg <= '0;
            end
          end
          RX_START: begin
            if (lk.tick && (rx_cnt_reg == (lk.bit_len >> 1) - 13'h0001)) begin
              rx_cnt_reg <= '0;
              rx_idx_reg <= 4'h0;
              rx_state_reg <= lk.rxd ? RX_IDLE : RX_BITS;
            end else if (lk.tick) begin
              rx_cnt_reg <= rx_cnt_reg + 13'h0001;
            end
          end
          RX_BITS: begin
            if (rx_bit_end) begin
              rx_cnt_reg <= '0;
              rx_shift_reg[rx_idx_reg] <= lk.rxd;
              rx_idx_reg <= rx_idx_reg + 4'h1;
              if (rx_idx_reg == (has_par ? 4'h8 : 4'h7)) begin
                rx_state_reg <= RX_STOP;
              end
            end else if (lk.tick) begin
              rx_cnt_reg <= rx_cnt_reg + 13'h0001;
            end
          end
          RX_STOP: begin
            if (rx_bit_end) begin
              rx_cnt_reg <= '0;
              rx_data_reg <= rx_shift_reg[7:0];
              rx_perr_reg <= has_par && (rx_shift_reg[8] != rx_exp_par);
              rx_ferr_reg <= !lk.rxd;
              rx_valid_reg <= 1'b1;
              rx_state_reg <= RX_IDLE;
            end else if (lk.tick) begin
              rx_cnt_reg <= rx_cnt_reg + 13'h0001;
            end
          end
        endcase
      end
    end
  end
endmodule

/* File: bench/async_serial_properties.sv */
`timescale 1ns/1ps
module async_serial_checker (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [async_serial_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [async_serial_pkg::NUM_PORTS-1:0] TXD,
  input wire logic [async_serial_pkg::NUM_PORTS-1:0] RX_EVENT,
  input wire logic WAKE
);
  import async_serial_pkg::*;
  logic clr_done;
  assign clr_done = PSEL && PENABLE && PWRITE && PADDR == 8'h1c && PWDATA[STAT_RX_DONE_BIT];
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence access_s;
    PSEL && PENABLE;
  endsequence
  sequence bad_addr_s;
    PADDR[7:6] != 2'h0 || PADDR[5:4] == 2'h3 || PADDR[1:0] != 2'h0;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  pready_ce_a: assert property (PREADY == CE)
    else $error("PREADY differs from CE");
  slverr_bad_a: assert property (access_s ##0 bad_addr_s |-> PSLVERR)
    else $error("no error on unmapped access");
  slverr_good_a: assert property (access_s ##0 (PADDR[7:6] == 2'h0 && PADDR[5:4] != 2'h3 && PADDR[1:0] == 2'h0)
      |-> !PSLVERR) else $error("error on mapped access");
  bad_read_zero_a: assert property (access_s ##0 !PWRITE ##0 bad_addr_s |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  // Read data only moves at a read setup cycle
  prdata_hold_a: assert property (!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
    else $error("read data moved");
  wake_or_a: assert property (WAKE == (RX_EVENT[1] || RX_EVENT[2]))
    else $error("wake not tied to port events");
  fixed_bit_a: assert property ($changed(TXD[0]) |=> $stable(TXD[0]) [*8])
    else $error("fixed port bit too short");
  port_a_bit_a: assert property ($changed(TXD[1]) |=> $stable(TXD[1]) [*7])
    else $error("port A bit too short");
  port_b_bit_a: assert property ($changed(TXD[2]) |=> $stable(TXD[2]) [*7])
    else $error("port B bit too short");
  txd_idle_a: assert property ($rose(NRST) |-> (TXD == 3'h7) [*3])
    else $error("line not idle high after reset");
  event_clear_a: assert property ($fell(RX_EVENT[1]) |-> $past(clr_done, 1) || $past(clr_done, 2))
    else $error("event dropped without clear");
endmodule

bind async_serial_ports async_serial_checker i_chk (
  .CLK, .NRST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
  .TXD, .RX_EVENT, .WAKE
);

/* File: bench/remote_serial.sv */
`timescale 1ns/1ps
module remote_serial (
  input wire logic clk,
  input wire logic [2:0] txd,
  output logic [2:0] rxd
);
  initial rxd = 3'h7;
  ////////////////////////////////////////////////////////////////////////////////
  // framed byte out
  task automatic send(input int pt, input logic [7:0] b, input logic [1:0] par, input bit bad,
      input bit sv, input int per);
    logic [10:0] f;
    int n;
    f = {sv, ^b ^ par[1] ^ bad, b, 1'b0};
    n = 11;
    if (par == 2'b00 || par == 2'b11) begin
      f = {1'b1, sv, b, 1'b0};
      n = 10;
    end
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxd[pt] <= f[i];
      repeat (per - 1) @(posedge clk);
    end
    // Released line returns to its idle-high level
    @(posedge clk);
    rxd[pt] <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // mid-bit capture
  // Start length is measured, so test bytes need bit 0 set
  task automatic grab(input int pt, input int per, input bit hasp, output logic [7:0] b,
      output logic p, output logic s, output int low);
    low = 0;
    do @(posedge clk); while (txd[pt] !== 1'b0);
    while (txd[pt] === 1'b0) begin
      low++;
      @(posedge clk);
    end
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = txd[pt];
      repeat (per) @(posedge clk);
    end
    p = txd[pt];
    if (hasp) repeat (per) @(posedge clk);
    s = txd[pt];
  endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import async_serial_pkg::*;
  logic CLK = 1'b0;
  logic NRST, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, WAKE;
  logic [ADDR_W-1:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [NUM_PORTS-1:0] RXD, TXD, RX_EVENT;
  int cyc = 0;
  int err_total = 0;
  int checks = 0;
  int pf[4] = '{6, 8, 10, 6};
  int pa[4] = '{1, 12, 14, 16};
  // Distinct source periods so a wrong source choice changes the bit time
  wire FIXED_PORT_BAUD_PIN = (cyc % 6) < 3;
  wire TOGGLE_TIMER_FOUR = (cyc % 8) < 4;
  wire TIMER_ZERO_HIGH_PWM_OUTPUT = (cyc % 10) < 5;
  wire LOW_SPEED_CRYSTAL_CLOCK = (cyc % 12) < 6;
  wire CERAMIC_MAIN_CLOCK = (cyc % 14) < 7;
  wire PORT_A_BAUD_PIN = (cyc % 16) < 8;
  wire PORT_B_BAUD_PIN = (cyc % 18) < 9;
  always #12.5 CLK = ~CLK;
  always @(posedge CLK) cyc <= cyc + 1;
  async_serial_ports i_dut (.CLK, .NRST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .RXD, .TXD, .FIXED_PORT_BAUD_PIN, .PORT_A_BAUD_PIN, .PORT_B_BAUD_PIN,
    .TOGGLE_TIMER_FOUR, .TIMER_ZERO_HIGH_PWM_OUTPUT, .LOW_SPEED_CRYSTAL_CLOCK, .CERAMIC_MAIN_CLOCK,
    .RX_EVENT, .WAKE);
  remote_serial i_far (.clk(CLK), .txd(TXD), .rxd(RXD));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic er);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] q;
    logic er;
    logic [31:0] wv[3] = '{32'h2, 32'h1fff, 32'hd};
    logic [31:0] ev[3] = '{32'h8, 32'h1000, 32'hd};
    apb(1'b0, 8'h10, 32'h0, q, er);
    chk(q, 32'h0);
    apb(1'b0, 8'h14, 32'h0, q, er);
    chk(q, 32'h8);
    apb(1'b0, 8'h40, 32'h0, q, er);
    chk({er, q[30:0]}, 32'h80000000);
    apb(1'b1, 8'h34, 32'h5, q, er);
    chk(er, 1'b1);
    apb(1'b0, 8'h06, 32'h0, q, er);
    chk(er, 1'b1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'h24, wv[i], q, er);
      apb(1'b0, 8'h24, 32'h0, q, er);
      chk(q, ev[i]);
    end
  endtask
  task automatic t_tx(input int pt, input logic [6:0] c, input logic [12:0] dv, input int per,
      input logic [7:0] b);
    logic [31:0] q;
    logic er, p, s, hasp;
    logic [7:0] g;
    int low, t0, nb, bl;
    hasp = c[2:1] == 2'b01 || c[2:1] == 2'b10;
    bl = (pt == 0) ? (c[6] ? 8 : 4) : int'(dv);
    nb = 10 + int'(hasp) + int'(c[3] && pt != 0);
    apb(1'b1, 8'(pt * 16), {25'h0, c}, q, er);
    apb(1'b1, 8'(pt * 16 + 4), {19'h0, dv}, q, er);
    fork
      i_far.grab(pt, per, hasp, g, p, s, low);
      begin
        apb(1'b1, 8'(pt * 16 + 8), {24'h0, b}, q, er);
        t0 = cyc;
        do apb(1'b0, 8'(pt * 16 + 12), 32'h0, q, er); while (q[12] !== 1'b1 && cyc - t0 < 9000);
      end
    join
    chk(g, b);
    chk(low, per);
    chk(s, 1'b1);
    if (hasp) chk(p, ^b ^ c[2]);
    chk(cyc - t0 >= nb * per + 2 && cyc - t0 <= nb * per + per / bl + 10, 1'b1);
    apb(1'b1, 8'(pt * 16 + 12), 32'h1000, q, er);
    apb(1'b0, 8'(pt * 16 + 12), 32'h0, q, er);
    chk(q[12], 1'b0);
  endtask
  task automatic t_rx(input int pt, input logic [6:0] c, input int per, input logic [7:0] b,
      input logic [1:0] par, input bit bad, input bit sv, input logic [11:0] e, input bit clr);
    logic [31:0] q;
    logic er;
    apb(1'b1, 8'(pt * 16), {25'h0, c}, q, er);
    apb(1'b1, 8'(pt * 16 + 4), 32'h8, q, er);
    i_far.send(pt, b, par, bad, sv, per);
    apb(1'b0, 8'(pt * 16 + 12), 32'h0, q, er);
    chk(q[11:0], e);
    chk({RX_EVENT[pt], WAKE}, {1'b1, pt != 0});
    if (clr) begin
      apb(1'b1, 8'(pt * 16 + 12), 32'h1f00, q, er);
      apb(1'b0, 8'(pt * 16 + 12), 32'h0, q, er);
      chk({q[12:8], RX_EVENT[pt]}, 6'h0);
    end
  endtask
  task automatic t_duplex();
    logic [31:0] q;
    logic er;
    fork
      t_tx(1, 7'h01, 8, 8, 8'h2d);
      begin
        repeat (8) @(posedge CLK);
        i_far.send(1, 8'hd4, 2'b00, 1'b0, 1'b1, 8);
      end
    join
    apb(1'b0, 8'h1c, 32'h0, q, er);
    chk(q[8:0], 9'h1d4);
    apb(1'b1, 8'h1c, 32'h1f00, q, er);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (80000) @(posedge CLK);
    err_total++;
    $display("ERROR at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    CE = 1'b1;
    NRST = 1'b0;
    repeat (10) @(posedge CLK);
    NRST <= 1'b1;
    repeat (4) @(posedge CLK);
    t_regs();
    for (int m = 0; m < 4; m++) t_tx(1, 7'(1 + 2 * m), 8, 8, 8'ha5);
    t_tx(1, 7'h09, 8, 8, 8'h3b);
    t_tx(2, 7'h0b, 13, 13, 8'h81);
    for (int s = 1; s < 4; s++) t_tx(1, 7'(1 + 16 * s), 8, 8 * pa[s], 8'h57);
    t_tx(2, 7'h31, 8, 8 * 18, 8'h6d);
    t_tx(0, 7'h09, 8, 24, 8'h99);
    for (int s = 0; s < 4; s++)
      for (int f = 0; f < 2; f++) t_tx(0, 7'(1 + 16 * s + 64 * f), 8, (4 + 4 * f) * pf[s], 8'hc3);
    t_rx(2, 7'h05, 8, 8'h9c, 2'b10, 1'b0, 1'b1, 12'h19c, 1'b0);
    t_rx(2, 7'h05, 8, 8'h9c, 2'b10, 1'b1, 1'b1, 12'hb9c, 1'b1);
    t_rx(1, 7'h03, 8, 8'h11, 2'b01, 1'b0, 1'b0, 12'h511, 1'b1);
    t_rx(0, 7'h41, 48, 8'he7, 2'b00, 1'b0, 1'b1, 12'h1e7, 1'b1);
    t_duplex();
    summarize();
  end
endmodule
